// [core/stfm_defs.svh]
// Constants for the servo terminal function map
`ifndef STFM_DEFS_SVH
`define STFM_DEFS_SVH

`define STFM_AW 8
`define STFM_OFS_DI_MAP_LO 8'h00
`define STFM_OFS_DI_MAP_HI 8'h04
`define STFM_OFS_DO_MAP 8'h08
`define STFM_OFS_DI_POL 8'h0C
`define STFM_OFS_ROT_THR 8'h10
`define STFM_OFS_STATUS 8'h14
`define STFM_OFS_ACT_DI_LO 8'h18
`define STFM_OFS_ACT_DI_HI 8'h1C
`define STFM_OFS_ACT_DO 8'h20

`define STFM_RST_DI_MAP 32'h0000_0000
`define STFM_RST_DO_MAP 32'h0006_4210
`define STFM_RST_DI_POL 32'h0000_0000
`define STFM_RST_ROT_THR 32'h0000_0014

`define STFM_FIELD_DI 8
`define STFM_FIELD_DO 4
`define STFM_CODE_W 6
`define STFM_NFUNC 64

`define STFM_FN_HOLD 6'h13
`define STFM_FN_POS_START 6'h14
`define STFM_FN_HOME 6'h15
`define STFM_FN_ORIGIN 6'h16
`define STFM_FN_AN_FWD 6'h17
`define STFM_FN_AN_REV 6'h18
`define STFM_FN_MODE_SW 6'h19
`define STFM_FN_JOG_FWD 6'h1A
`define STFM_FN_JOG_REV 6'h1B
`define STFM_FN_OVERHEAT 6'h1C
`define STFM_FN_FL_EN 6'h1D
`define STFM_FN_FL_REARM 6'h1E
`define STFM_FN_GANTRY 6'h1F
`define STFM_FN_CAM_RUN 6'h20
`define STFM_FN_CAM_SEL 6'h21

`define STFM_OC_READY 4'h0
`define STFM_OC_ENERGIZED 4'h1
`define STFM_OC_ROTATION 4'h2
`define STFM_OC_SPEED_OK 4'h3
`define STFM_OC_POS_DONE 4'h4
`define STFM_OC_TORQUE_LT 4'h5
`define STFM_OC_FAULT 4'h6
`define STFM_OC_BRAKE 4'h7
`define STFM_OC_OVERLOAD 4'h8
`define STFM_OC_SPEED_LT 4'h9
`define STFM_OC_INT_TRIG 4'hA
`define STFM_OC_DEVIATION 4'hB
`define STFM_OC_HOMED 4'hC
`define STFM_OC_RESERVED 4'hD
`define STFM_OC_CAM 4'hE
`define STFM_OC_NONE 4'hF

`define STFM_RESP_OKAY 2'h0
`define STFM_RESP_SLVERR 2'h2

`endif

// [core/stfm_pkg.sv]
// Types for the servo terminal function map
package stfm_pkg;

   // Drive state feeding the status outputs
   typedef struct packed {
      logic ready;
      logic alarm_pending;
      logic energized;
      logic [15:0] speed_abs;
      logic speed_reached;
      logic pos_done;
      logic torque_limited;
      logic fault;
      logic brake;
      logic overload_warn;
      logic speed_limited;
      logic internal_trigger_active;
      logic deviation_excess;
      logic homing_done;
      logic home_sensor;
      logic cam_running;
   } stfm_status_s;

   // Commands to the motion core, all registered
   typedef struct packed {
      logic position_hold;
      logic internal_position_start_in;
      logic homing_start_in;
      logic origin_reference_in;
      logic analog_fwd_in;
      logic analog_rev_in;
      logic mode_switch_in;
      logic jog_fwd_in;
      logic jog_rev_in;
      logic motor_overheat_in;
      logic fixed_length_irq_enable;
      logic fixed_length_trigger;
      logic fixed_length_irq_rearm;
      logic gantry_sync_start_in;
      logic cam_run_in;
      logic cam_table_select_in;
   } stfm_cmd_s;

endpackage

// [core/stfm_top.sv]
// Terminal function routing with AXI4-Lite configuration
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "stfm_defs.svh"
module stfm_top #(
   parameter int NUM_DI = 8,
   parameter int NUM_DO = 4
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic RESTART,
   input wire logic [NUM_DI-1:0] DI_PIN,
   input wire logic FL_PROBE,
   input wire stfm_pkg::stfm_status_s STATUS_IN,
   output stfm_pkg::stfm_cmd_s CMD_OUT,
   output logic [NUM_DO-1:0] DO_PIN,
   output logic FAULT_PIN,
   input wire logic [`STFM_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [`STFM_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);

   localparam int DO_ALL = NUM_DO + 1;
   localparam int DI_MW = NUM_DI * `STFM_FIELD_DI;
   localparam int DO_MW = DO_ALL * `STFM_FIELD_DO;

   // Pending selections written by software, then the rotation threshold, which takes effect at once
   logic [31:0] pend_di_lo_ff;
   logic [31:0] pend_di_hi_ff;
   logic [31:0] pend_do_ff;
   logic [31:0] pend_pol_ff;
   logic [31:0] rot_thr_ff;
   // Selections in force
   logic [63:0] act_di_ff;
   logic [DO_MW-1:0] act_do_ff;
   logic [NUM_DI-1:0] act_pol_ff;

   logic [NUM_DI-1:0] di_prev_ff;
   logic probe_prev_ff;
   logic armed_ff;
   stfm_pkg::stfm_cmd_s cmd_ff;
   logic [DO_ALL-1:0] out_ff;

   // AXI bus state
   logic aw_got_ff;
   logic w_got_ff;
   logic [`STFM_AW-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;

   // ---------------- Input terminals ----------------
   logic [NUM_DI-1:0] di_act;
   logic [NUM_DI-1:0] di_rise;
   logic [`STFM_NFUNC-1:0] lvl_hot [NUM_DI];
   logic [`STFM_NFUNC-1:0] edge_hot [NUM_DI];
   logic [`STFM_NFUNC-1:0] fn_lvl;
   logic [`STFM_NFUNC-1:0] fn_edge;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DI; gi++) begin : g_di
         wire [`STFM_CODE_W-1:0] code = act_di_ff[gi*`STFM_FIELD_DI +: `STFM_CODE_W];
         assign di_act[gi] = DI_PIN[gi] ^ act_pol_ff[gi];
         assign di_rise[gi] = di_act[gi] & ~di_prev_ff[gi];
         assign lvl_hot[gi] = di_act[gi] ? (`STFM_NFUNC'(1) << code) : '0;
         assign edge_hot[gi] = di_rise[gi] ? (`STFM_NFUNC'(1) << code) : '0;
      end
   endgenerate

   // Codes with no function here land on bits that nothing reads
   always_comb begin
      fn_lvl = '0;
      fn_edge = '0;
      for (int i = 0; i < NUM_DI; i++) begin
         fn_lvl = fn_lvl | lvl_hot[i];
         fn_edge = fn_edge | edge_hot[i];
      end
   end

   wire probe_rise = FL_PROBE & ~probe_prev_ff;
   wire fl_fire = fn_lvl[`STFM_FN_FL_EN] & probe_rise & armed_ff;
   // Re-arm beats a trigger landing in the same cycle
   wire nxt_armed = (armed_ff & ~fl_fire) | fn_edge[`STFM_FN_FL_REARM];

   stfm_pkg::stfm_cmd_s nxt_cmd;
   always_comb begin
      nxt_cmd.position_hold = fn_lvl[`STFM_FN_HOLD];
      nxt_cmd.internal_position_start_in = fn_edge[`STFM_FN_POS_START];
      nxt_cmd.homing_start_in = fn_edge[`STFM_FN_HOME];
      nxt_cmd.origin_reference_in = fn_edge[`STFM_FN_ORIGIN];
      nxt_cmd.analog_fwd_in = fn_lvl[`STFM_FN_AN_FWD];
      nxt_cmd.analog_rev_in = fn_lvl[`STFM_FN_AN_REV];
      nxt_cmd.mode_switch_in = fn_lvl[`STFM_FN_MODE_SW];
      nxt_cmd.jog_fwd_in = fn_lvl[`STFM_FN_JOG_FWD];
      nxt_cmd.jog_rev_in = fn_lvl[`STFM_FN_JOG_REV];
      nxt_cmd.motor_overheat_in = fn_lvl[`STFM_FN_OVERHEAT];
      nxt_cmd.fixed_length_irq_enable = fn_lvl[`STFM_FN_FL_EN];
      nxt_cmd.fixed_length_trigger = fl_fire;
      nxt_cmd.fixed_length_irq_rearm = fn_edge[`STFM_FN_FL_REARM];
      nxt_cmd.gantry_sync_start_in = fn_lvl[`STFM_FN_GANTRY];
      nxt_cmd.cam_run_in = fn_lvl[`STFM_FN_CAM_RUN];
      nxt_cmd.cam_table_select_in = fn_lvl[`STFM_FN_CAM_SEL];
   end

   // ---------------- Output terminals ----------------
   logic [15:0] stat_vec;
   always_comb begin
      stat_vec = '0;
      stat_vec[`STFM_OC_READY] = STATUS_IN.ready & ~STATUS_IN.fault & ~STATUS_IN.alarm_pending;
      stat_vec[`STFM_OC_ENERGIZED] = STATUS_IN.energized;
      stat_vec[`STFM_OC_ROTATION] = STATUS_IN.speed_abs > rot_thr_ff[15:0];
      stat_vec[`STFM_OC_SPEED_OK] = STATUS_IN.speed_reached;
      stat_vec[`STFM_OC_POS_DONE] = STATUS_IN.pos_done;
      stat_vec[`STFM_OC_TORQUE_LT] = STATUS_IN.torque_limited;
      stat_vec[`STFM_OC_FAULT] = STATUS_IN.fault;
      stat_vec[`STFM_OC_BRAKE] = STATUS_IN.brake;
      stat_vec[`STFM_OC_OVERLOAD] = STATUS_IN.overload_warn;
      stat_vec[`STFM_OC_SPEED_LT] = STATUS_IN.speed_limited;
      stat_vec[`STFM_OC_INT_TRIG] = STATUS_IN.internal_trigger_active;
      stat_vec[`STFM_OC_DEVIATION] = STATUS_IN.deviation_excess;
      stat_vec[`STFM_OC_HOMED] = STATUS_IN.homing_done & STATUS_IN.home_sensor;
      stat_vec[`STFM_OC_RESERVED] = 1'b0;
      stat_vec[`STFM_OC_CAM] = STATUS_IN.cam_running;
      stat_vec[`STFM_OC_NONE] = 1'b0;
   end

   logic [DO_ALL-1:0] nxt_out;
   genvar go;
   generate
      // Last entry is the fault terminal, same selector width
      for (go = 0; go < DO_ALL; go++) begin : g_do
         assign nxt_out[go] = stat_vec[act_do_ff[go*`STFM_FIELD_DO +: `STFM_FIELD_DO]];
      end
   endgenerate

   assign DO_PIN = out_ff[NUM_DO-1:0];
   assign FAULT_PIN = out_ff[NUM_DO];
   assign CMD_OUT = cmd_ff;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         di_prev_ff <= '0;
         probe_prev_ff <= 1'b0;
         armed_ff <= 1'b1;
         cmd_ff <= '0;
         out_ff <= '0;
      end else begin
         di_prev_ff <= di_act;
         probe_prev_ff <= FL_PROBE;
         armed_ff <= nxt_armed;
         cmd_ff <= nxt_cmd;
         out_ff <= nxt_out;
      end
   end

   // Mapping swaps only on restart so a live machine never changes wiring under load
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         act_di_ff <= {`STFM_RST_DI_MAP, `STFM_RST_DI_MAP};
         act_do_ff <= DO_MW'(`STFM_RST_DO_MAP);
         act_pol_ff <= NUM_DI'(`STFM_RST_DI_POL);
      end else if (RESTART) begin
         act_di_ff <= {pend_di_hi_ff, pend_di_lo_ff};
         act_do_ff <= pend_do_ff[DO_MW-1:0];
         act_pol_ff <= pend_pol_ff[NUM_DI-1:0];
      end
   end

   // ---------------- AXI4-Lite slave ----------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] stb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (stb[b]) begin
            res[b*8 +: 8] = dat[b*8 +: 8];
         end
      end
      return res;
   endfunction

   assign S_AXI_AWREADY = ~aw_got_ff & ~bvalid_ff;
   assign S_AXI_WREADY = ~w_got_ff & ~bvalid_ff;
   assign S_AXI_ARREADY = ~rvalid_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;

   wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID & S_AXI_WREADY;
   wire wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
   wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;

   wire [`STFM_AW-1:0] wa = awaddr_ff;
   wire wsel_lo = wa == `STFM_OFS_DI_MAP_LO;
   wire wsel_hi = wa == `STFM_OFS_DI_MAP_HI;
   wire wsel_do = wa == `STFM_OFS_DO_MAP;
   wire wsel_pol = wa == `STFM_OFS_DI_POL;
   wire wsel_thr = wa == `STFM_OFS_ROT_THR;
   wire wr_ok = wsel_lo | wsel_hi | wsel_do | wsel_pol | wsel_thr;

   wire [31:0] status_word = {16'h0000, 2'h0, armed_ff, out_ff, NUM_DI'(di_act)};
   wire [`STFM_AW-1:0] ra = S_AXI_ARADDR;
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (ra)
         `STFM_OFS_DI_MAP_LO: rd_mux = pend_di_lo_ff;
         `STFM_OFS_DI_MAP_HI: rd_mux = pend_di_hi_ff;
         `STFM_OFS_DO_MAP: rd_mux = pend_do_ff;
         `STFM_OFS_DI_POL: rd_mux = pend_pol_ff;
         `STFM_OFS_ROT_THR: rd_mux = rot_thr_ff;
         `STFM_OFS_STATUS: rd_mux = status_word;
         `STFM_OFS_ACT_DI_LO: rd_mux = act_di_ff[31:0];
         `STFM_OFS_ACT_DI_HI: rd_mux = act_di_ff[63:32];
         `STFM_OFS_ACT_DO: rd_mux = 32'(act_do_ff);
         default: begin
            rd_mux = '0;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `STFM_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= S_AXI_AWADDR;
         end
         if (w_take) begin
            w_got_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? `STFM_RESP_OKAY : `STFM_RESP_SLVERR;
         end else if (bvalid_ff & S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Pending selections survive RESTART, standing in for stored parameters
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pend_di_lo_ff <= `STFM_RST_DI_MAP;
         pend_di_hi_ff <= `STFM_RST_DI_MAP;
         pend_do_ff <= `STFM_RST_DO_MAP;
         pend_pol_ff <= `STFM_RST_DI_POL;
         rot_thr_ff <= `STFM_RST_ROT_THR;
      end else if (wr_go) begin
         if (wsel_lo) pend_di_lo_ff <= merge(pend_di_lo_ff, wdata_ff, wstrb_ff);
         if (wsel_hi) pend_di_hi_ff <= merge(pend_di_hi_ff, wdata_ff, wstrb_ff);
         if (wsel_do) pend_do_ff <= merge(pend_do_ff, wdata_ff, wstrb_ff);
         if (wsel_pol) pend_pol_ff <= merge(pend_pol_ff, wdata_ff, wstrb_ff);
         if (wsel_thr) rot_thr_ff <= merge(rot_thr_ff, wdata_ff, wstrb_ff);
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= `STFM_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux;
         rresp_ff <= rd_ok ? `STFM_RESP_OKAY : `STFM_RESP_SLVERR;
      end else if (rvalid_ff & S_AXI_RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end

endmodule // stfm_top

// [verif/stfm_top_properties.sv]
// Port-level checks for the terminal function map
`timescale 1ns/1ps
module stfm_top_properties #(
   parameter int NUM_DI = 8,
   parameter int NUM_DO = 4
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire stfm_pkg::stfm_status_s STATUS_IN,
   input wire stfm_pkg::stfm_cmd_s CMD_OUT,
   input wire logic FAULT_PIN,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   // Address and data are latched first, the response is set one edge later
   chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
      else $error("write not answered");
   chk_write_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");
   chk_bresp_done: assert property (S_AXI_BVALID && S_AXI_BREADY |-> ##1 !S_AXI_BVALID)
      else $error("write response not released");
   chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read not answered");
   chk_read_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while data pending");
   chk_home_once: assert property (CMD_OUT.homing_start_in |=> !CMD_OUT.homing_start_in)
      else $error("home search pulse too long");
   chk_start_once: assert property ($rose(CMD_OUT.internal_position_start_in) |=> $fell(CMD_OUT.internal_position_start_in))
      else $error("position start pulse too long");
   chk_trig_once: assert property (CMD_OUT.fixed_length_trigger |=> !CMD_OUT.fixed_length_trigger)
      else $error("fixed length trigger too long");
   chk_rearm_once: assert property (CMD_OUT.fixed_length_irq_rearm |=> !CMD_OUT.fixed_length_irq_rearm)
      else $error("rearm pulse too long");
   chk_fault_follow: assert property (1'b1 |-> FAULT_PIN == $past(STATUS_IN.fault))
      else $error("fault terminal does not follow fault state");
endmodule // stfm_top_properties

bind stfm_top stfm_top_properties #(.NUM_DI(NUM_DI), .NUM_DO(NUM_DO)) i_stfm_top_properties (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .STATUS_IN(STATUS_IN), .CMD_OUT(CMD_OUT), .FAULT_PIN(FAULT_PIN),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));

// [verif/stfm_host_model.sv]
// Host controller driving the input terminals
`timescale 1ns/1ps
module stfm_host_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic [7:0] pin_req,
   input wire logic probe_req,
   output logic [7:0] di_pin,
   output logic fl_probe
);
   logic [7:0] pin_ff;
   logic probe_ff;
   always_ff @(posedge clk) begin
      pin_ff <= pin_req;
      probe_ff <= probe_req;
   end
   // Slow host updates its outputs one scan later
   assign di_pin = slow ? pin_ff : pin_req;
   assign fl_probe = slow ? probe_ff : probe_req;
endmodule // stfm_host_model

// [verif/stfm_top_test.sv]
// Self-checking bench for the terminal function map
`timescale 1ns/1ps
module stfm_top_test;
   logic clk = 1'b0, rst = 1'b1, rs = 1'b0, slow = 1'b0, probe = 1'b0;
   logic [7:0] pins = 8'h00, di, aa = 8'h00;
   logic av = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic awr, wr_rdy, bv, arr, rv, fp, flp;
   logic [31:0] wd = 32'h0000_0000, rd;
   logic [1:0] bresp, rresp;
   logic [3:0] dop;
   logic [15:0] cv;
   stfm_pkg::stfm_status_s st = '0;
   stfm_pkg::stfm_cmd_s cmd;
   int error_cnt = 0, tests_run = 0, cyc = 0, h = 0;
   int lvl[9] = '{23, 24, 25, 26, 27, 28, 31, 32, 33};
   int lbit[9] = '{11, 10, 9, 8, 7, 6, 2, 1, 0};
   assign cv = cmd;
   stfm_top i_stfm_top (.CLK_SYS(clk), .RESET(rst), .RESTART(rs), .DI_PIN(di), .FL_PROBE(flp), .STATUS_IN(st),
      .CMD_OUT(cmd), .DO_PIN(dop), .FAULT_PIN(fp), .S_AXI_AWADDR(aa), .S_AXI_AWVALID(av), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(aa), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
   stfm_host_model i_stfm_host_model (.clk(clk), .slow(slow), .pin_req(pins), .probe_req(probe), .di_pin(di),
      .fl_probe(flp));
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, da, dw, tb;
      logic [1:0] r;
      da = 1'b0;
      dw = 1'b0;
      aa <= a;
      wd <= d;
      av <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(negedge clk);
         ta = av & awr;
         tw = wv & wr_rdy;
         @(posedge clk);
         if (ta) av <= 1'b0;
         if (tw) wv <= 1'b0;
         da |= ta;
         dw |= tw;
      end while (!(da && dw));
      do begin
         @(negedge clk);
         tb = bv;
         r = bresp;
         @(posedge clk);
      end while (!tb);
      br <= 1'b0;
      // Let an edge pass so a following call never re-drives the strobe in this step
      @(posedge clk);
      check("write response", 32'(er), 32'(r));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic t;
      logic [31:0] d;
      logic [1:0] r;
      aa <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(negedge clk);
         t = arr;
         @(posedge clk);
      end while (!t);
      arv <= 1'b0;
      do begin
         @(negedge clk);
         t = rv;
         d = rd;
         r = rresp;
         @(posedge clk);
      end while (!t);
      rr <= 1'b0;
      @(posedge clk);
      check("read data", e, d);
      check("read response", 32'(er), 32'(r));
   endtask
   task automatic restart_map();
      rs <= 1'b1;
      @(posedge clk);
      rs <= 1'b0;
      @(posedge clk);
   endtask
   task automatic watch(input logic [15:0] m, input int n);
      repeat (n) begin
         @(negedge clk);
         h += int'((cv & m) != 16'h0000);
      end
      @(posedge clk);
   endtask
   task automatic hit(input int p, input logic [15:0] m, input int n);
      h = 0;
      pins[p] <= 1'b1;
      watch(m, n);
      pins[p] <= 1'b0;
      watch(m, 4);
   endtask
   task automatic fire();
      h = 0;
      probe <= 1'b1;
      watch(16'h0010, 3);
      probe <= 1'b0;
      watch(16'h0010, 3);
   endtask
   // Near case sits just outside the condition of each output code
   function automatic stfm_pkg::stfm_status_s stim(input int c, input logic n);
      stfm_pkg::stfm_status_s s;
      s = '0;
      case (c)
         0: begin
            s.ready = 1'b1;
            s.alarm_pending = n;
         end
         1: s.energized = !n;
         2: s.speed_abs = n ? 16'h0014 : 16'h0015;
         3: s.speed_reached = !n;
         4: s.pos_done = !n;
         5: s.torque_limited = !n;
         6: s.fault = !n;
         7: s.brake = !n;
         8: s.overload_warn = !n;
         9: s.speed_limited = !n;
         10: s.internal_trigger_active = !n;
         11: s.deviation_excess = !n;
         12: begin
            s.homing_done = 1'b1;
            s.home_sensor = !n;
         end
         14: s.cam_running = !n;
         default: s = n ? '0 : '1;
      endcase
      return s;
   endfunction
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(8'h08, 32'h0006_4210, 2'h0);
      rd_chk(8'h10, 32'h0000_0014, 2'h0);
      rd_chk(8'hF0, 32'h0000_0000, 2'h2);
      wr(8'h14, 32'h0000_FFFF, 2'h2);
      st.ready <= 1'b1;
      st.pos_done <= 1'b1;
      repeat (3) @(posedge clk);
      check("default outputs", 32'h0000_0009, 32'(dop));
      st <= '0;
      wr(8'h00, 32'h1615_1413, 2'h0);
      wr(8'h04, 32'h0F17_1E1D, 2'h0);
      hit(2, 16'h2000, 2);
      check("home before restart", 32'h0000_0000, h);
      restart_map();
      hit(2, 16'h2000, 2);
      check("home pulses", 32'h0000_0001, h);
      hit(1, 16'h4000, 5);
      check("start pulses", 32'h0000_0001, h);
      hit(3, 16'h1000, 1);
      check("origin pulses", 32'h0000_0001, h);
      hit(0, 16'h8000, 5);
      check("hold cycles", 32'h0000_0005, h);
      hit(7, 16'hFFFF, 3);
      check("reserved input", 32'h0000_0000, h);
      slow <= 1'b1;
      fire();
      check("trigger disabled", 32'h0000_0000, h);
      pins[4] <= 1'b1;
      repeat (4) @(posedge clk);
      check("enable level", 32'h0000_0001, 32'(cmd.fixed_length_irq_enable));
      fire();
      check("trigger", 32'h0000_0001, h);
      fire();
      check("trigger disarmed", 32'h0000_0000, h);
      hit(5, 16'h0008, 2);
      check("rearm pulses", 32'h0000_0001, h);
      fire();
      check("trigger rearmed", 32'h0000_0001, h);
      pins[4] <= 1'b0;
      slow <= 1'b0;
      foreach (lvl[i]) begin
         wr(8'h04, 32'h0F00_1E1D | (32'(lvl[i]) << 16), 2'h0);
         restart_map();
         hit(6, 16'h0001 << lbit[i], 3);
         check("level cycles", 32'h0000_0003, h);
      end
      wr(8'h0C, 32'h0000_0040, 2'h0);
      restart_map();
      repeat (3) @(posedge clk);
      check("closed contact idle", 32'h0000_0001, 32'(cmd.cam_table_select_in));
      pins[6] <= 1'b1;
      repeat (3) @(posedge clk);
      check("closed contact open", 32'h0000_0000, 32'(cmd.cam_table_select_in));
      pins[6] <= 1'b0;
      for (int c = 0; c < 16; c++) begin
         wr(8'h08, 32'h0006_0000 | c, 2'h0);
         restart_map();
         st <= stim(c, 1'b0);
         repeat (3) @(posedge clk);
         check("output on", 32'(c != 13 && c != 15), 32'(dop[0]));
         st <= stim(c, 1'b1);
         repeat (3) @(posedge clk);
         check("output off", 32'h0000_0000, 32'(dop[0]));
      end
      test_done();
   end
endmodule // stfm_top_test
